// file: shared/escr_pkg.sv
// constants, state type and check-bit functions for the edac sram control register block
package escr_pkg;
  localparam int ESCR_DATA_W = 32;
  localparam int ESCR_CODE_W = 7;
  localparam int ESCR_WORD_W = ESCR_DATA_W + ESCR_CODE_W;
  // register map, word index within the apb window
  localparam logic [5:0] ESCR_CFG_IDX = 6'h00;
  // field positions of edac_control_status
  localparam int ESCR_TCB_LSB = 0;
  localparam int ESCR_EN_BIT = 7;
  localparam int ESCR_RB_BIT = 8;
  localparam int ESCR_WB_BIT = 9;
  localparam int ESCR_SIZE_LSB = 10;
  localparam int ESCR_SIZE_W = 3;
  localparam int ESCR_TALLY_LSB = 13;
  // reset values
  localparam logic ESCR_EN_RST = 1'h0;
  localparam logic ESCR_RB_RST = 1'h0;
  localparam logic ESCR_WB_RST = 1'h0;
  localparam logic [7:0] ESCR_TALLY_RST = 8'h00;
  // ahb encodings
  localparam logic [1:0] ESCR_HRESP_OKAY = 2'h0;
  localparam logic [1:0] ESCR_HRESP_ERROR = 2'h1;
  localparam logic [2:0] ESCR_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] ESCR_HSIZE_HALF = 3'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CHECK, ST_ERR} escr_state_t;

  // extended hamming: data bits sit on non-power-of-two positions 3..38
  function automatic logic [ESCR_CODE_W-1:0] escr_encode(input logic [ESCR_DATA_W-1:0] d);
    logic [ESCR_CODE_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p < 39; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        for (int k = 0; k < 6; k++)
        begin
          if (p[k])
            c[k] = c[k] ^ d[j];
        end
        j++;
      end
    end
    c[6] = (^d) ^ (^c[5:0]);
    return c;
  endfunction

  // flips the data bit whose position equals the syndrome; check-bit errors leave data alone
  function automatic logic [ESCR_DATA_W-1:0] escr_fix(input logic [ESCR_DATA_W-1:0] d, input logic [5:0] s);
    logic [ESCR_DATA_W-1:0] r;
    int j;
    r = d;
    j = 0;
    for (int p = 1; p < 39; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (6'(p) == s)
          r[j] = ~r[j];
        j++;
      end
    end
    return r;
  endfunction
endpackage

// file: core/escr_top.sv
// edac protected on-chip sram with ahb memory port and apb control/status register
// Notes on behaviour
// - the control/status register sits at word offset zero of the apb window
// - with the counter built in, single_error_tally starts at bit 13, counter_width wide
// - tally counts corrected single errors, saturates at all ones; writing one clears bit
// - bits 12:10 read the log2 of memory size, read only
// - write_check_override stores test_check_bits as check bits on ahb writes; scrub write-backs always store encoded check bits
// - read_check_bypass copies fetched check bits into test_check_bits on reads, subword writes
// - edac_on enables checking and correction; check bits are encoded on writes either way; cleared means plain memory behaviour
// - test_check_bits is a seven-bit read-write field at bits 6:0
// - unused upper register bits read as zero
// - reset clears enable, bypass, override and tally; test_check_bits stays uninitialised
// - a build option includes or omits edac checking and the register; check bits are still encoded and stored
// - optional scrub writes corrected data back after a single-error read
// - counter width is a build option from 1 to 8 bits
// - optional input pipeline adds one wait state to reads and subword writes
// - ahb window decoded from 12-bit base and mask, mask defaulting to all ones
// - apb window selected by a 12-bit address field and a mask
// - fixed vendor and device identification codes are presented for bus scanning
// - an uncorrectable fetched word aborts with the two-cycle ahb error response
// - single_fix_pulse is high exactly one cycle per corrected single error
`timescale 1ns/100ps
module escr_top
  import escr_pkg::*;
#(
  parameter int KBYTES = 1,
  parameter bit EDAC_EN = 1'b1,
  parameter bit SCRUB_EN = 1'b0,
  parameter bit CNT_EN = 1'b1,
  parameter int CNT_W = 8,
  parameter bit PIPE_EN = 1'b0,
  parameter logic [11:0] HADDR_BASE = 12'h000,
  parameter logic [11:0] HADDR_MASK = 12'hfff,
  parameter logic [11:0] PADDR_BASE = 12'h000,
  parameter logic [11:0] PADDR_MASK = 12'hfff,
  // identification values are arbitrary
  parameter logic [7:0] VENDOR_ID = 8'h5a,
  parameter logic [11:0] DEVICE_ID = 12'h3c3
)(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hready_o,
  output logic [1:0] hresp_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic single_fix_pulse_o,
  output logic [31:0] pnp_id_o
);
  localparam int WORDS = KBYTES * 256;
  localparam int AW = $clog2(WORDS);
  localparam logic [ESCR_SIZE_W-1:0] MEM_LOG2 = ESCR_SIZE_W'($clog2(KBYTES));
  localparam logic [CNT_W-1:0] TALLY_MAX = {CNT_W{1'b1}};

  logic [ESCR_WORD_W-1:0] mem [WORDS];
  logic [ESCR_WORD_W-1:0] mem_q;
  escr_state_t state;
  logic [AW-1:0] x_idx;
  logic [1:0] x_lane;
  logic [2:0] x_size;
  logic x_write;
  logic edac_on;
  logic rcb;
  logic wco;
  logic [ESCR_CODE_W-1:0] test_check_bits;
  logic [CNT_W-1:0] tally;

  // address phase; the captured copy doubles as the input pipeline register
  logic win_hit;
  logic accept;
  assign win_hit = ((haddr_i[31:20] ^ HADDR_BASE) & HADDR_MASK) == 12'h000;
  assign accept = (state == ST_IDLE) && hsel_i && htrans_i[1] && hready_i && win_hit;

  // decode of the fetched word
  logic edac_act;
  logic [ESCR_CODE_W-1:0] code_calc;
  logic [5:0] syn;
  logic single;
  logic dbl;
  logic [31:0] fixed;
  logic x_word;
  logic [31:0] lane_mask;
  logic [31:0] merged;
  assign edac_act = edac_on && EDAC_EN;
  assign code_calc = escr_encode(mem_q[31:0]);
  assign syn = code_calc[5:0] ^ mem_q[37:32];
  assign single = edac_act && (^mem_q);
  assign dbl = edac_act && !(^mem_q) && (syn != 6'h00);
  assign fixed = single ? escr_fix(mem_q[31:0], syn) : mem_q[31:0];
  assign x_word = !(x_size == ESCR_HSIZE_BYTE || x_size == ESCR_HSIZE_HALF);

  always_comb
  begin
    lane_mask = 32'hffffffff;
    if (x_size == ESCR_HSIZE_BYTE)
      lane_mask = 32'h000000ff << {x_lane, 3'h0};
    else if (x_size == ESCR_HSIZE_HALF)
      lane_mask = 32'h0000ffff << {x_lane[1], 4'h0};
  end
  assign merged = x_word ? hwdata_i : ((fixed & ~lane_mask) | (hwdata_i & lane_mask));

  // memory write decision in the check cycle
  logic in_check;
  logic fetch_used;
  logic wr_en;
  logic [31:0] wr_data;
  logic [ESCR_CODE_W-1:0] wr_code;
  assign in_check = state == ST_CHECK;
  assign fetch_used = in_check && !(x_write && x_word);
  always_comb
  begin
    wr_en = 1'b0;
    wr_data = merged;
    wr_code = wco ? test_check_bits : escr_encode(merged);
    if (in_check && x_write && (x_word || !dbl))
      wr_en = 1'b1;
    else if (in_check && !x_write && single && SCRUB_EN && EDAC_EN)
    begin
      wr_en = 1'b1;
      wr_data = fixed;
      wr_code = escr_encode(fixed);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (accept)
      mem_q <= mem[haddr_i[AW+1:2]];
    if (wr_en)
      mem[x_idx] <= {wr_code, wr_data};
  end

  // ahb transfer sequencing
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      hready_o <= 1'b1;
      hresp_o <= ESCR_HRESP_OKAY;
      hrdata_o <= 32'h00000000;
      x_idx <= '0;
      x_lane <= 2'h0;
      x_size <= 3'h0;
      x_write <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          hresp_o <= ESCR_HRESP_OKAY;
          if (accept)
          begin
            x_idx <= haddr_i[AW+1:2];
            x_lane <= haddr_i[1:0];
            x_size <= hsize_i;
            x_write <= hwrite_i;
            hready_o <= 1'b0;
            // extra cycle only where the fetched word is used
            if (PIPE_EN && !(hwrite_i && !(hsize_i == ESCR_HSIZE_BYTE || hsize_i == ESCR_HSIZE_HALF)))
              state <= ST_WAIT;
            else
              state <= ST_CHECK;
          end
          else
            hready_o <= 1'b1;
        end
        ST_WAIT:
          state <= ST_CHECK;
        ST_CHECK:
        begin
          if (dbl && !(x_write && x_word))
          begin
            hresp_o <= ESCR_HRESP_ERROR;
            state <= ST_ERR;
          end
          else
          begin
            if (!x_write)
              hrdata_o <= fixed;
            hready_o <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_ERR:
        begin
          hready_o <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      single_fix_pulse_o <= 1'b0;
    else
      single_fix_pulse_o <= fetch_used && single;
  end

  // apb register window
  logic apb_hit;
  logic cfg_wr;
  logic cfg_rd;
  assign apb_hit = psel_i && (((paddr_i[19:8] ^ PADDR_BASE) & PADDR_MASK) == 12'h000)
    && (paddr_i[7:2] == ESCR_CFG_IDX);
  assign cfg_wr = apb_hit && penable_i && pwrite_i && EDAC_EN;
  assign cfg_rd = apb_hit && !penable_i && !pwrite_i;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      edac_on <= ESCR_EN_RST;
      rcb <= ESCR_RB_RST;
      wco <= ESCR_WB_RST;
    end
    else if (cfg_wr)
    begin
      edac_on <= pwdata_i[ESCR_EN_BIT];
      rcb <= pwdata_i[ESCR_RB_BIT];
      wco <= pwdata_i[ESCR_WB_BIT];
    end
  end

  // left without reset on purpose; the fetched-code load wins over a software write
  always_ff @(posedge core_clk_i)
  begin
    if (fetch_used && rcb)
      test_check_bits <= mem_q[38:32];
    else if (cfg_wr)
      test_check_bits <= pwdata_i[ESCR_TCB_LSB +: ESCR_CODE_W];
  end

  // a count arriving with a clear is applied to the cleared value, so it is not lost
  logic [CNT_W-1:0] tally_kept;
  logic tally_inc;
  assign tally_kept = cfg_wr ? (tally & ~pwdata_i[ESCR_TALLY_LSB +: CNT_W]) : tally;
  assign tally_inc = fetch_used && single && CNT_EN;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tally <= ESCR_TALLY_RST[CNT_W-1:0];
    else if (tally_inc && tally_kept != TALLY_MAX)
      tally <= tally_kept + 1'b1;
    else
      tally <= tally_kept;
  end

  logic [31:0] cfg_word;
  always_comb
  begin
    cfg_word = 32'h00000000;
    cfg_word[ESCR_TCB_LSB +: ESCR_CODE_W] = test_check_bits;
    cfg_word[ESCR_EN_BIT] = edac_on;
    cfg_word[ESCR_RB_BIT] = rcb;
    cfg_word[ESCR_WB_BIT] = wco;
    cfg_word[ESCR_SIZE_LSB +: ESCR_SIZE_W] = MEM_LOG2;
    if (CNT_EN)
      cfg_word[ESCR_TALLY_LSB +: CNT_W] = tally;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prdata_o <= 32'h00000000;
      pnp_id_o <= 32'h00000000;
    end
    else
    begin
      pnp_id_o <= {VENDOR_ID, DEVICE_ID, 12'h000};
      if (cfg_rd)
        prdata_o <= EDAC_EN ? cfg_word : 32'h00000000;
      else if (!apb_hit)
        prdata_o <= 32'h00000000;
    end
  end

  a_fix_one_cycle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    single_fix_pulse_o |=> !single_fix_pulse_o) else $error("fix pulse longer than one cycle");

  a_tally_saturates: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (tally == TALLY_MAX && !cfg_wr) |=> tally == TALLY_MAX) else $error("tally wrapped");

  a_tally_counts: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (tally_inc && !cfg_wr && tally != TALLY_MAX) |=> tally == $past(tally) + 1'b1)
    else $error("tally missed a count");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    prdata_o[31:ESCR_TALLY_LSB+CNT_W] == '0) else $error("reserved bits nonzero");

  a_size_field: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (cfg_rd && EDAC_EN) |=> prdata_o[12:10] == MEM_LOG2) else $error("size field wrong");

  a_error_two_cycle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (in_check && dbl && !(x_write && x_word)) |=> (hresp_o == ESCR_HRESP_ERROR && !hready_o)
    ##1 (hresp_o == ESCR_HRESP_ERROR && hready_o)) else $error("bad error response");

  a_edac_off_plain: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (in_check && !edac_on) |=> (!single_fix_pulse_o && hready_o && hresp_o == ESCR_HRESP_OKAY))
    else $error("checking active while disabled");

  a_bypass_load: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (fetch_used && rcb) |=> test_check_bits == $past(mem_q[38:32])) else $error("check bits not captured");

  a_override_code: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_en && x_write && wco) |-> wr_code == test_check_bits) else $error("override code not used");
endmodule

// file: tb/escr_bus_model.sv
// ahb master and apb bridge model facing the memory port and the register port
`timescale 1ns/100ps
module escr_bus_model (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  input wire logic [1:0] hresp_i,
  input wire logic [31:0] prdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [31:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // transfers that never saw hready; any nonzero count is one mismatch in the bench's final report
  int timeouts = 0;
  // size of the next ahb transfer, word unless a scenario asks for less
  logic [2:0] xfer_size = 3'h2;
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 32'h0;
    pwdata_o = 32'h0;
  end

  // transfer of size xfer_size; the address phase is launched at the next edge without sampling hready
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic [1:0] resp, output logic err_mid);
    int n;
    n = 0;
    err_mid = 1'b0;
    @(posedge clk_i);
    #1;
    hsel_o = 1'b1;
    haddr_o = addr;
    htrans_o = 2'h2;
    hwrite_o = wr;
    hsize_o = xfer_size;
    @(posedge clk_i);
    #1;
    hsel_o = 1'b0;
    htrans_o = 2'h0;
    // released address shows garbage, not the last value
    haddr_o = ~addr;
    hwdata_o = wd;
    do
    begin
      @(posedge clk_i);
      n++;
      if (hresp_i === 2'h1 && hready_i === 1'b0)
        err_mid = 1'b1;
    end
    while (hready_i !== 1'b1 && n < 10);
    if (hready_i !== 1'b1)
      timeouts++;
    rd = hrdata_i;
    resp = hresp_i;
    // let the answering edge pass before the data bus moves
    #1;
    hwdata_o = ~wd;
  endtask

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    #1;
    psel_o = 1'b1;
    penable_o = 1'b0;
    pwrite_o = wr;
    paddr_o = addr;
    pwdata_o = wd;
    @(posedge clk_i);
    #1;
    penable_o = 1'b1;
    @(posedge clk_i);
    rd = prdata_i;
    #1;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwdata_o = ~wd;
    paddr_o = ~addr;
  endtask
endmodule

// file: tb/escr_top_tb.sv
// self-checking bench for the edac sram control register block
`timescale 1ns/100ps
module escr_top_tb;
  import escr_pkg::*;
  // small tally so saturation is reached in a few reads
  localparam int CW = 2;
  logic core_clk, rstn, hsel, hwrite, hready, psel, penable, pwrite, pulse;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, pnp, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic mid;
  logic [1:0] resp;
  int error_cnt = 0;
  int compares = 0;
  int pulses = 0;

  escr_top #(.KBYTES(4), .CNT_W(CW)) dut (.core_clk_i(core_clk), .rstn_i(rstn), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hready_o(hready), .hresp_o(hresp), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .single_fix_pulse_o(pulse), .pnp_id_o(pnp));

  escr_bus_model bm (.clk_i(core_clk), .hready_i(hready), .hrdata_i(hrdata), .hresp_i(hresp),
    .prdata_i(prdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (pulse === 1'b1)
      pulses++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // expected register image; size field is log2 of 4 kbytes
  function automatic logic [31:0] cfg(input logic [CW-1:0] t, input logic [2:0] ctl, input logic [6:0] test_check_bits);
    return ({30'h0, t} << 13) | 32'h800 | {22'h0, ctl, test_check_bits};
  endfunction

  task automatic final_report();
    check("bus timeouts", 32'(bm.timeouts), 32'h0);
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset();
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("cfg after reset", rd & 32'hffffff80, cfg(2'h0, 3'h0, 7'h0));
    bm.apb(1'b0, 32'h4, 32'h0, rd);
    check("unmapped offset", rd, 32'h0);
    check("id word", pnp, {8'h5a, 12'h3c3, 12'h0});
    $display("test reset done");
  endtask

  task automatic t_fields();
    bm.apb(1'b1, 32'h0, 32'hffffffff, rd);
    bm.apb(1'b1, 32'h4, 32'h0, rd);
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("cfg all ones", rd, cfg(2'h0, 3'h7, 7'h7f));
    bm.apb(1'b1, 32'h0, 32'h80, rd);
    $display("test fields done");
  endtask

  task automatic t_edac();
    bm.ahb(1'b1, 32'h10, 32'ha5a51234, rd, resp, mid);
    bm.ahb(1'b0, 32'h10, 32'h0, rd, resp, mid);
    check("clean read", rd, 32'ha5a51234);
    check("clean pulses", 32'(pulses), 32'h0);
    // override stores code zero under data one: single error on data bit 0
    bm.apb(1'b1, 32'h0, 32'h280, rd);
    bm.ahb(1'b1, 32'h20, 32'h1, rd, resp, mid);
    bm.apb(1'b1, 32'h0, 32'h1d5, rd);
    bm.ahb(1'b0, 32'h20, 32'h0, rd, resp, mid);
    check("corrected data", rd, 32'h0);
    check("corrected resp", {30'h0, resp}, 32'h0);
    check("one pulse", 32'(pulses), 32'h1);
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("loaded check bits", rd, cfg(2'h1, 3'h3, 7'h0));
    repeat (3) bm.ahb(1'b0, 32'h20, 32'h0, rd, resp, mid);
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("saturated tally", rd, cfg(2'h3, 3'h3, 7'h0));
    check("four pulses", 32'(pulses), 32'h4);
    bm.apb(1'b1, 32'h0, 32'h2180, rd);
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("tally bit cleared", rd, cfg(2'h2, 3'h3, 7'h0));
    $display("test edac done");
  endtask

  task automatic t_double();
    bm.apb(1'b1, 32'h0, 32'h283, rd);
    bm.ahb(1'b1, 32'h30, 32'h0, rd, resp, mid);
    bm.apb(1'b1, 32'h0, 32'h80, rd);
    bm.ahb(1'b0, 32'h30, 32'h0, rd, resp, mid);
    check("first error cycle", {31'h0, mid}, 32'h1);
    check("final error cycle", {30'h0, resp}, 32'h1);
    check("no pulse on double", 32'(pulses), 32'h4);
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("tally after double", rd & 32'hffffff80, cfg(2'h2, 3'h1, 7'h0));
    $display("test double done");
  endtask

  task automatic t_off();
    bm.apb(1'b1, 32'h0, 32'h0, rd);
    bm.ahb(1'b0, 32'h20, 32'h0, rd, resp, mid);
    check("raw data", rd, 32'h1);
    check("raw resp", {30'h0, resp}, 32'h0);
    bm.ahb(1'b0, 32'h30, 32'h0, rd, resp, mid);
    check("raw resp double", {30'h0, resp}, 32'h0);
    check("no pulse when off", 32'(pulses), 32'h4);
    $display("test off done");
  endtask

  task automatic t_subword();
    bm.apb(1'b1, 32'h0, 32'h1d5, rd);
    // byte into lane 1 of the word still holding a single error
    bm.xfer_size = ESCR_HSIZE_BYTE;
    bm.ahb(1'b1, 32'h21, 32'h0000ab00, rd, resp, mid);
    bm.xfer_size = 3'h2;
    check("subword resp", {30'h0, resp}, 32'h0);
    check("subword pulse", 32'(pulses), 32'h5);
    bm.apb(1'b0, 32'h0, 32'h0, rd);
    check("subword tally", rd, cfg(2'h3, 3'h3, 7'h0));
    bm.ahb(1'b0, 32'h20, 32'h0, rd, resp, mid);
    check("merged word", rd, 32'h0000ab00);
    check("fresh check bits", 32'(pulses), 32'h5);
    $display("test subword done");
  endtask

  initial
  begin
    rstn = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_fields();
    t_edac();
    t_double();
    t_off();
    t_subword();
    final_report();
  end

  // whole run is well under two hundred cycles; ten thousand means a hang
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
